// *** pwc_apb_slave.sv ***
// APB slave: write strobe, registered read data and error, zero wait states
module pwc_apb_slave
  import pwc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Bus request
  input wire pwc_apb_req_t req_in,
  // Register file side
  input wire logic [31:0] rd_data_in,
  input wire logic addr_ok_in,
  output logic wr_stb_out,
  // Bus answer
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  output logic pready_out
);

  pwc_apb_state_t st;
  pwc_apb_state_t next_st;
  logic setup;

  assign setup = req_in.psel && !req_in.penable;

  // Read data and error captured in setup, presented in access
  always_comb begin
    next_st = st;
    if (setup) begin
      next_st.pslverr = !addr_ok_in;
      next_st.prdata = (req_in.pwrite || !addr_ok_in) ? 32'h0000_0000 : rd_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign wr_stb_out = req_in.psel && req_in.penable && req_in.pwrite && addr_ok_in;
  assign prdata_out = st.prdata;
  assign pslverr_out = st.pslverr;
  assign pready_out = 1'b1;

endmodule : pwc_apb_slave

// *** pwc_pkg.sv ***
// Types shared by the PWM channel block
`include "pwc_regs.svh"

package pwc_pkg;

  // One channel's complete state
  typedef struct packed {
    logic en;
    logic align;
    logic pol;
    logic [7:0] div;
    logic [7:0] cnt;
    logic dir_up;
    logic [7:0] per_buf;
    logic [7:0] per_act;
    logic [7:0] duty_buf;
    logic [7:0] duty_act;
    logic out;
  } pwc_ch_t;

  typedef struct packed {
    pwc_ch_t [`PWC_NUM_CH-1:0] ch;
  } pwc_state_t;

  // APB request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`PWC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } pwc_apb_req_t;

  // APB slave internal state
  typedef struct packed {
    logic [31:0] prdata;
    logic pslverr;
  } pwc_apb_state_t;

  // Tick divider state
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } pwc_div_state_t;

endpackage : pwc_pkg

// *** pwc_properties.sv ***
// Port-level checker of the PWM channel block
`include "pwc_regs.svh"

module pwc_properties
  import pwc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Bus
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`PWC_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Waveforms
  input wire logic [`PWC_NUM_CH-1:0] pwm_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic acc;
  logic wr;
  logic rdc;
  logic [1:0] ch;
  logic [3:0] en_q;
  logic [7:0] per_q [4];
  assign acc = psel_in && penable_in;
  assign wr = acc && pwrite_in;
  assign rdc = acc && !pwrite_in && paddr_in[11:6] == 6'h00;
  assign ch = paddr_in[5:4];
  // Shadow of written enables and periods
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_q <= 4'h0;
      per_q <= '{default: 8'hFF};
    end else if (wr && paddr_in[11:6] == 6'h00 && paddr_in[3:0] == 4'h0) begin
      en_q[ch] <= pwdata_in[0];
    end else if (wr && paddr_in[11:6] == 6'h00 && paddr_in[3:0] == 4'h8) begin
      per_q[ch] <= pwdata_in[7:0];
    end else if (wr && paddr_in == `PWC_ADDR_ENABLES) begin
      en_q <= pwdata_in[3:0];
    end
  end
  a_ready_high: assert property (pready_out) else $error("pready low");
  a_unaligned_error: assert property (acc && paddr_in[1:0] != 2'h0 |->
    pslverr_out && prdata_out == 32'h0) else $error("unaligned access not refused");
  a_unmapped_error: assert property (acc && paddr_in > 12'h044 |-> pslverr_out)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && paddr_in[1:0] == 2'h0 && paddr_in <= 12'h044
    |-> !pslverr_out) else $error("mapped access refused");
  a_period_readback: assert property (rdc && paddr_in[3:0] == 4'h8 |->
    prdata_out == {24'h0, per_q[ch]}) else $error("period read not last written");
  a_counter_width: assert property (rdc && paddr_in[3:0] == 4'h4 |->
    prdata_out[31:8] == 24'h0) else $error("counter wider than 8 bits");
  a_enables_readback: assert property (acc && !pwrite_in && paddr_in == `PWC_ADDR_ENABLES
    |-> prdata_out == {28'h0, en_q}) else $error("enables read wrong");
  a_frozen_output: assert property (en_q == 4'h0 && $past(en_q) == 4'h0 && !$past(wr)
    && !$past(wr, 2) |-> $stable(pwm_out)) else $error("output moved while disabled");
  c_counter_write: cover property (wr && paddr_in[11:6] == 6'h00 && paddr_in[3:0] == 4'h4);
  c_refused: cover property (acc && pslverr_out);
  c_wave_rise: cover property ($rose(pwm_out[0]));
endmodule : pwc_properties

bind pwc_top pwc_properties pwc_properties_inst (.sys_clk_in, .rst_n_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
  .pslverr_out, .pwm_out);

// *** pwc_regs.svh ***
// Register map, field positions and reset values of the PWM channel block
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH

`define PWC_NUM_CH 4
`define PWC_CH_W 2
`define PWC_ADDR_W 12

// Per-channel register window: byte address = channel * stride + offset
`define PWC_CH_STRIDE 12'h010
`define PWC_OFS_CTRL 4'h0
`define PWC_OFS_COUNTER 4'h4
`define PWC_OFS_PERIOD 4'h8
`define PWC_OFS_DUTY 4'hC

// Global registers
`define PWC_ADDR_STATUS 12'h040
`define PWC_ADDR_ENABLES 12'h044

// Control register fields
`define PWC_CTRL_ENABLE 0
`define PWC_CTRL_ALIGN 1
`define PWC_CTRL_POL 2
`define PWC_CTRL_DIV_LSB 8
`define PWC_CTRL_DIV_MSB 15

// Status register fields
`define PWC_STAT_OUT_LSB 0
`define PWC_STAT_DIR_LSB 8

// Reset values
`define PWC_RST_PERIOD 8'hFF
`define PWC_RST_DUTY 8'h00
`define PWC_RST_DIV 8'h00
`define PWC_RST_COUNT 8'h00

`endif

// *** pwc_tick_div.sv ***
// Channel clock tick generator: one pulse every div+1 system clocks
module pwc_tick_div
  import pwc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic [7:0] div_in,
  // Tick
  output logic tick_out
);

  pwc_div_state_t st;
  pwc_div_state_t next_st;

  always_comb begin
    next_st = st;
    if (st.cnt >= div_in) begin
      next_st.cnt = 8'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
      next_st.tick = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_out = st.tick;

endmodule : pwc_tick_div

// *** pwc_top.sv ***
// PWM channel counters, period and duty double buffering, APB register file
// Function
// RULE_01 - Period write while disabled loads buffer and active value together.
// RULE_02 - Period read returns last written value, not the active one.
// RULE_03 - Left aligned: output period is channel clock period times period value.
// RULE_04 - Centre aligned: output period is channel clock period times twice period.
// RULE_05 - Each channel has its own 8-bit up/down counter on its tick.
// RULE_06 - Counter equal to active duty toggles the output flip-flop.
// RULE_07 - Counter reads are allowed anytime and never disturb counting.
// RULE_08 - Counter write clears count, sets up, loads buffers, sets output.
// RULE_09 - Disable freezes counter; re-enable resumes from the frozen count.
// RULE_10 - Disabled with period zero: counter resets on next channel tick.
// RULE_11 - Counter write while enabled starts a new period immediately.
// RULE_12 - Counter clears to zero when the effective period ends.
// RULE_13 - Period changes apply only at safe points, never mid waveform.
// RULE_14 - Software should write the counter before enabling for a clean start.
// RULE_15 - Period match: left restarts at zero, centre reverses to count down.
// RULE_16 - While enabled, buffers move to active values at period end.
//
// Our own choices: the register addresses and the APB slave port.
`include "pwc_regs.svh"

module pwc_top
  import pwc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`PWC_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Waveforms
  output logic [`PWC_NUM_CH-1:0] pwm_out
);

  localparam int NCH = `PWC_NUM_CH;

  pwc_state_t st;
  pwc_state_t next_st;
  pwc_apb_req_t req;
  logic [NCH-1:0] tick;
  logic wr_stb;
  logic addr_ok;
  logic [31:0] rd_word;
  logic is_ch;
  logic [`PWC_CH_W-1:0] sel_ch;
  logic [3:0] sel_ofs;

  assign req.psel = psel_in;
  assign req.penable = penable_in;
  assign req.pwrite = pwrite_in;
  assign req.paddr = paddr_in;
  assign req.pwdata = pwdata_in;

  // Channel window select
  assign is_ch = (paddr_in < (`PWC_CH_STRIDE * NCH)) && (paddr_in[1:0] == 2'h0);
  assign sel_ch = paddr_in[`PWC_CH_W+3:4];
  assign sel_ofs = paddr_in[3:0];

  pwc_apb_slave pwc_apb_slave_inst (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .req_in(req),
    .rd_data_in(rd_word),
    .addr_ok_in(addr_ok),
    .wr_stb_out(wr_stb),
    .prdata_out(prdata_out),
    .pslverr_out(pslverr_out),
    .pready_out(pready_out)
  );

  // Free-running channel clocks
  for (genvar g = 0; g < NCH; g++) begin : g_div
    pwc_tick_div pwc_tick_div_inst (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .div_in(st.ch[g].div),
      .tick_out(tick[g])
    );
  end

  // Read decode; addr_ok also gates writes
  always_comb begin
    pwc_ch_t rc;
    rc = st.ch[sel_ch];
    rd_word = 32'h0000_0000;
    addr_ok = 1'b0;
    if (is_ch && sel_ofs == `PWC_OFS_CTRL) begin
      addr_ok = 1'b1;
      rd_word[`PWC_CTRL_ENABLE] = rc.en;
      rd_word[`PWC_CTRL_ALIGN] = rc.align;
      rd_word[`PWC_CTRL_POL] = rc.pol;
      rd_word[`PWC_CTRL_DIV_MSB:`PWC_CTRL_DIV_LSB] = rc.div;
    end else if (is_ch && sel_ofs == `PWC_OFS_COUNTER) begin
      addr_ok = 1'b1;
      rd_word[7:0] = rc.cnt; // RULE_07
    end else if (is_ch && sel_ofs == `PWC_OFS_PERIOD) begin
      addr_ok = 1'b1;
      rd_word[7:0] = rc.per_buf; // RULE_02
    end else if (is_ch && sel_ofs == `PWC_OFS_DUTY) begin
      addr_ok = 1'b1;
      rd_word[7:0] = rc.duty_buf;
    end else if (paddr_in == `PWC_ADDR_STATUS) begin
      addr_ok = 1'b1;
      for (int i = 0; i < NCH; i++) begin
        rd_word[`PWC_STAT_OUT_LSB + i] = st.ch[i].out;
        rd_word[`PWC_STAT_DIR_LSB + i] = st.ch[i].dir_up;
      end
    end else if (paddr_in == `PWC_ADDR_ENABLES) begin
      addr_ok = 1'b1;
      for (int i = 0; i < NCH; i++) begin
        rd_word[i] = st.ch[i].en;
      end
    end
  end

  // Channel counters and register writes
  always_comb begin
    pwc_ch_t c;
    logic end_p;
    logic [7:0] nc;
    logic hit;
    c = '0;
    end_p = 1'b0;
    nc = 8'h00;
    hit = 1'b0;
    next_st = st;
    for (int i = 0; i < NCH; i++) begin
      c = st.ch[i];
      end_p = 1'b0;
      nc = c.cnt;
      hit = wr_stb && is_ch && (sel_ch == i[`PWC_CH_W-1:0]);
      if (tick[i]) begin // RULE_05
        if (c.en) begin
          if (!c.align) begin
            // Left aligned: per_act ticks per period
            if ({1'b0, c.cnt} + 9'h001 >= {1'b0, c.per_act}) begin // RULE_03
              end_p = 1'b1;
            end else begin
              nc = c.cnt + 8'h01;
              c.cnt = nc;
              if (nc == c.duty_act) begin
                c.out = ~c.out; // RULE_06
              end
            end
          end else if (c.dir_up) begin
            // Centre aligned: up to per_act, then down to zero
            nc = c.cnt + 8'h01;
            c.cnt = nc;
            if (nc >= c.per_act) begin
              c.dir_up = 1'b0; // RULE_15
            end
            if (nc == c.duty_act) begin
              c.out = ~c.out; // RULE_06
            end
          end else begin
            if (c.cnt <= 8'h01) begin
              end_p = 1'b1; // RULE_04
            end else begin
              nc = c.cnt - 8'h01;
              c.cnt = nc;
              if (nc == c.duty_act) begin
                c.out = ~c.out; // RULE_06
              end
            end
          end
        end else if (c.per_act == 8'h00) begin
          c.cnt = `PWC_RST_COUNT; // RULE_10
          c.dir_up = 1'b1;
        end
      end
      // Disabled: tick only resets the count above when per_act is zero, else count stays frozen
      // RULE_09
      if (end_p) begin
        c.cnt = `PWC_RST_COUNT; // RULE_12
        c.dir_up = 1'b1; // RULE_15
        c.per_act = c.per_buf; // RULE_16
        c.duty_act = c.duty_buf; // RULE_13
        c.out = c.pol;
      end
      if (hit && sel_ofs == `PWC_OFS_CTRL) begin
        c.en = pwdata_in[`PWC_CTRL_ENABLE];
        c.align = pwdata_in[`PWC_CTRL_ALIGN];
        c.pol = pwdata_in[`PWC_CTRL_POL];
        c.div = pwdata_in[`PWC_CTRL_DIV_MSB:`PWC_CTRL_DIV_LSB];
      end else if (hit && sel_ofs == `PWC_OFS_COUNTER) begin
        // Any value clears; enabled channels restart a period at once
        c.cnt = `PWC_RST_COUNT; // RULE_08
        c.dir_up = 1'b1; // RULE_08
        c.per_act = c.per_buf; // RULE_08
        c.duty_act = c.duty_buf; // RULE_08
        c.out = c.pol; // RULE_11
      end else if (hit && sel_ofs == `PWC_OFS_PERIOD) begin
        c.per_buf = pwdata_in[7:0];
        if (!st.ch[i].en) begin
          c.per_act = pwdata_in[7:0]; // RULE_01
        end
      end else if (hit && sel_ofs == `PWC_OFS_DUTY) begin
        c.duty_buf = pwdata_in[7:0];
        if (!st.ch[i].en) begin
          c.duty_act = pwdata_in[7:0];
        end
      end
      if (wr_stb && paddr_in == `PWC_ADDR_ENABLES) begin
        c.en = pwdata_in[i];
      end
      next_st.ch[i] = c;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NCH; i++) begin
        st.ch[i].en <= 1'b0;
        st.ch[i].align <= 1'b0;
        st.ch[i].pol <= 1'b0;
        st.ch[i].div <= `PWC_RST_DIV;
        st.ch[i].cnt <= `PWC_RST_COUNT;
        st.ch[i].dir_up <= 1'b1;
        st.ch[i].per_buf <= `PWC_RST_PERIOD;
        st.ch[i].per_act <= `PWC_RST_PERIOD;
        st.ch[i].duty_buf <= `PWC_RST_DUTY;
        st.ch[i].duty_act <= `PWC_RST_DUTY;
        st.ch[i].out <= 1'b0;
      end
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pwm_out[i] = st.ch[i].out;
    end
  end

endmodule : pwc_top

// *** pwc_top_test.sv ***
// Self-checking bench of the PWM channel block
`include "pwc_regs.svh"

module pwc_top_test
  import pwc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [3:0] pwm_out;
  logic [31:0] seed = 32'h0000002F;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int total_checks = 0;
  pwc_top pwc_top_inst (.sys_clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .pwm_out);
  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One transfer; idle edge first so strobes never change twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  // Cycles between two rising edges of one waveform
  task automatic period_of(input int c, output int n);
    time t0;
    @(posedge pwm_out[c]);
    t0 = $time;
    @(posedge pwm_out[c]);
    n = int'(($time - t0) / 10);
  endtask : period_of
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (30000) @(posedge sys_clk_in);
    miscompares++;
    print_verdict();
  end
  initial begin
    int p;
    int d;
    int dv;
    int n;
    int m;
    logic [11:0] b;
    logic [31:0] f;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    apb(1'b0, 12'h080, 32'h0);
    check({31'h0, err}, 32'h1);
    for (int c = 0; c < 4; c++) begin
      b = 12'(c * 16);
      apb(1'b0, b + 12'h008, 32'h0);
      check(rd, 32'h000000FF);
      dv = int'(xs() % 3);
      p = int'(xs() % 10) + 4;
      d = int'(xs() % 32'(p - 1)) + 1;
      m = (c % 2 == 1) ? 2 : 1;
      f = {16'h0, 8'(dv), 6'h0, 1'(c % 2), 1'b1};
      apb(1'b1, b + 12'h008, 32'(p));
      apb(1'b1, b + 12'h00C, 32'(d));
      apb(1'b1, b, f);
      period_of(c, n);
      check(32'(n), 32'(p * (dv + 1) * m));
      repeat (3) apb(1'b0, b + 12'h004, 32'h0);
      period_of(c, n);
      check(32'(n), 32'(p * (dv + 1) * m));
      p = p + 3;
      apb(1'b1, b + 12'h008, 32'(p));
      apb(1'b0, b + 12'h008, 32'h0);
      check(rd, 32'(p));
      period_of(c, n);
      period_of(c, n);
      check(32'(n), 32'(p * (dv + 1) * m));
      apb(1'b1, b, f & 32'hFFFFFFFE);
      apb(1'b0, b + 12'h004, 32'h0);
      f = rd;
      repeat (20) @(posedge sys_clk_in);
      apb(1'b0, b + 12'h004, 32'h0);
      check(rd, f);
      apb(1'b1, b + 12'h008, 32'h0);
      repeat (4) @(posedge sys_clk_in);
      apb(1'b0, b + 12'h004, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, b, {16'h0, 8'(dv), 8'h04});
      apb(1'b1, b + 12'h004, xs());
      apb(1'b0, b + 12'h004, 32'h0);
      check(rd, 32'h0);
      check({31'h0, pwm_out[c]}, 32'h1);
    end
    apb(1'b0, `PWC_ADDR_STATUS, 32'h0);
    check(rd, 32'h00000F0F);
    apb(1'b0, `PWC_ADDR_ENABLES, 32'h0);
    check(rd, 32'h0);
    print_verdict();
  end
endmodule : pwc_top_test
